// File: src/rbl_pkg.sv
// Constants of the byte-load block
package rbl_pkg;
    // Opcodes and prefixes
    localparam logic [7:0] OP_BUF_BYTE     = 8'hef;
    localparam logic [7:0] OP_BUF_COLOR    = 8'hdf;
    localparam logic [7:0] OP_UPPER_MOVE   = 8'hc0;
    localparam logic [7:0] OP_ALTERNATE_MODE_ONE_FLAG_PREFIX  = 8'h3d;
    localparam logic [7:0] OP_ALTERNATE_MODE_TWO_FLAG_PREFIX  = 8'h3e;
    localparam logic [7:0] OP_ALT3_PREFIX  = 8'h3f;
    localparam logic [3:0] OP_HI_INC       = 4'hd;
    localparam logic [3:0] OP_HI_WORD_IMM  = 4'hf;
    localparam logic [3:0] OP_HI_BYTE_IMM  = 4'ha;
    localparam logic [3:0] OP_HI_TO        = 4'h1;
    localparam logic [3:0] OP_HI_WITH      = 4'h2;
    localparam logic [3:0] OP_HI_FROM      = 4'hb;
    // Register numbers and data constants
    localparam logic [3:0] REG_DEFAULT     = 4'h0;
    localparam logic [3:0] REG_ROM_POINTER = 4'he;
    localparam logic [3:0] REG_LAST_INC    = 4'he;
    localparam logic [15:0] WORD_ONE       = 16'h0001;
    localparam logic [7:0] BYTE_ZERO       = 8'h00;
    localparam logic [15:0] WORD_RESET     = 16'h0000;
    localparam logic [7:0] BANK_RESET      = 8'h00;
    // Register bus offsets
    localparam logic [3:0] ADDR_OPCODE     = 4'h0;
    localparam logic [3:0] ADDR_REG_SEL    = 4'h1;
    localparam logic [3:0] ADDR_REG_DATA   = 4'h2;
    localparam logic [3:0] ADDR_STATUS     = 4'h3;
    localparam logic [3:0] ADDR_COLOR      = 4'h4;
    localparam logic [3:0] ADDR_BANK       = 4'h5;
    localparam logic [3:0] ADDR_FETCH      = 4'h6;
    // Status field positions
    localparam int ST_BUSY       = 0;
    localparam int ST_ALTERNATE_MODE_ONE_FLAG       = 1;
    localparam int ST_ALTERNATE_MODE_TWO_FLAG       = 2;
    localparam int ST_PREFIX     = 3;
    localparam int ST_SIGN       = 4;
    localparam int ST_ZERO       = 5;
    localparam int ST_OVERFLOW   = 6;
    localparam int ST_CARRY      = 7;
    localparam int ST_BUF_VALID  = 8;
    // Execution states
    typedef enum logic [2:0] {
        RBL_IDLE      = 3'b000,
        RBL_WAIT_BUF  = 3'b001,
        RBL_IMM_LOW   = 3'b011,
        RBL_IMM_HIGH  = 3'b010,
        RBL_IMM_BYTE  = 3'b110
    } rbl_state_t;
endpackage

// File: src/rbl_rom_fetch.sv
// ROM read buffer fetch unit
`timescale 1ns/10ps
`default_nettype none
module rbl_rom_fetch (
    input  wire logic        clock,        // Core clock
    input  wire logic        rst,          // Synchronous reset
    input  wire logic        start,        // Begin a fetch
    input  wire logic [15:0] pointer,      // Address within bank
    input  wire logic [7:0]  bank,         // ROM bank
    input  wire logic        rom_ready,    // ROM data valid (synchronised)
    input  wire logic [7:0]  rom_data,     // ROM data byte
    output logic      [23:0] rom_addr,     // Address to ROM
    output logic             rom_req,      // Read request to ROM
    output logic      [7:0]  buf_data,     // Read buffer contents
    output logic             buf_valid     // Buffer holds fresh data
);
    // ==========
    // Fetch sequencing
    always_ff @(posedge clock) begin
        if (rst) begin
            rom_addr  <= 24'h000000;
            rom_req   <= 1'b0;
            buf_data  <= 8'h00;
            buf_valid <= 1'b0;
        end else if (start) begin
            rom_addr  <= {bank, pointer};
            rom_req   <= 1'b1;
            buf_valid <= 1'b0;
        end else if (rom_req && rom_ready) begin
            buf_data  <= rom_data;
            rom_req   <= 1'b0;
            buf_valid <= 1'b1;
        end
    end
endmodule // rbl_rom_fetch
`default_nettype wire

// File: src/rbl_core.sv
// Byte-load and immediate-load core
// What this block does
// - Zero-extend load: buffer to low, high cleared
// - Register fourteen addresses ROM buffer fetches
// - Bank select alone starts no fetch
// - No destination prefix means register zero
// - Zero-extend load waits on buffer readiness
// - Upper-half load: buffer high, source low
// - Lower-half load: buffer low, source high
// - Signed load replicates buffer bit seven
// - Buffer-to-color loads color register
// - Prefixed loads wait on buffer readiness
// - Upper-byte move: source high to low
// - Upper-byte move sets sign, zero flags
// - Byte immediate sign-extends into register
// - Word immediate loads any register
// - Source and destination default to zero
// - Word immediate takes low byte first
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module rbl_core (
    input  wire logic        clock,      // 125 MHz core clock
    input  wire logic        rst,        // Synchronous reset, active high
    input  wire logic [3:0]  addr,       // Register bus address
    input  wire logic [15:0] wdata,      // Register bus write data
    input  wire logic        wr,         // Write strobe
    input  wire logic        rd,         // Read strobe
    input  wire logic        rom_ready,  // ROM data valid pin
    input  wire logic [7:0]  rom_data,   // ROM data pins
    output logic      [15:0] rdata,      // Read data, cycle after strobe
    output logic      [23:0] rom_addr,   // ROM address pins
    output logic             rom_req,    // ROM read request
    output logic             busy        // Instruction in progress
);
    // ==========
    // State
    logic [15:0] regs [0:15];
    rbl_pkg::rbl_state_t state_reg;
    logic [7:0]  color_reg;
    logic [7:0]  bank_reg;
    logic [3:0]  src_reg;
    logic [3:0]  dst_reg;
    logic [3:0]  sel_reg;
    logic [3:0]  imm_reg_num;
    logic [7:0]  op_reg;
    logic [7:0]  imm_low_reg;
    logic        alternate_mode_one_flag_reg;
    logic        alternate_mode_two_flag_reg;
    logic        prefix_reg;
    logic        sign_reg;
    logic        zero_reg;
    logic        overflow_reg;
    logic        carry_reg;
    logic        rdy_m_reg;
    logic        rdy_s_reg;
    logic [7:0]  dat_m_reg;
    logic [7:0]  dat_s_reg;
    logic        fetch_start;
    logic [7:0]  buf_data;
    logic        buf_valid;
    logic        wr_op;
    logic        done;
    logic        wr_en;
    logic [3:0]  wr_idx;
    logic [15:0] wr_val;
    logic [15:0] src_val;
    logic        op_wr;
    logic        reg_wr;
    logic        fetch_pend_reg;

    // ==========
    // Pin synchronisers
    always_ff @(posedge clock) begin
        if (rst) begin
            rdy_m_reg <= 1'b0;
            rdy_s_reg <= 1'b0;
            dat_m_reg <= 8'h00;
            dat_s_reg <= 8'h00;
        end else begin
            rdy_m_reg <= rom_ready;
            rdy_s_reg <= rdy_m_reg;
            dat_m_reg <= rom_data;
            dat_s_reg <= dat_m_reg;
        end
    end

    // ==========
    // Read buffer fetch
    rbl_rom_fetch u_fetch (
        .clock     (clock),
        .rst       (rst),
        .start     (fetch_start),
        .pointer   (regs[rbl_pkg::REG_ROM_POINTER]),
        .bank      (bank_reg),
        .rom_ready (rdy_s_reg),
        .rom_data  (dat_s_reg),
        .rom_addr  (rom_addr),
        .rom_req   (rom_req),
        .buf_data  (buf_data),
        .buf_valid (buf_valid)
    );

    // Pointer writes fetch a cycle later, once the new pointer stands
    always_ff @(posedge clock) begin
        if (rst) begin
            fetch_pend_reg <= 1'b0;
        end else begin
            fetch_pend_reg <= (wr_en && wr_idx == rbl_pkg::REG_ROM_POINTER)
                              || (reg_wr && sel_reg == rbl_pkg::REG_ROM_POINTER);
        end
    end

    assign fetch_start = (wr && addr == rbl_pkg::ADDR_FETCH) || fetch_pend_reg;
    assign op_wr   = wr && addr == rbl_pkg::ADDR_OPCODE;
    assign wr_op   = op_wr && state_reg == rbl_pkg::RBL_IDLE;
    assign reg_wr  = wr && addr == rbl_pkg::ADDR_REG_DATA && state_reg == rbl_pkg::RBL_IDLE;
    assign src_val = regs[src_reg];

    // ==========
    // Result selection
    always_comb begin
        wr_en  = 1'b0;
        wr_idx = dst_reg;
        wr_val = rbl_pkg::WORD_RESET;
        done   = 1'b0;
        case (state_reg)
            rbl_pkg::RBL_IDLE: begin
                if (wr_op) begin
                    if (wdata[7:0] == rbl_pkg::OP_UPPER_MOVE) begin
                        wr_en  = 1'b1;
                        wr_val = {rbl_pkg::BYTE_ZERO, src_val[15:8]};
                        done   = 1'b1;
                    end else if (wdata[7:4] == rbl_pkg::OP_HI_INC
                                 && wdata[3:0] <= rbl_pkg::REG_LAST_INC) begin
                        wr_en  = 1'b1;
                        wr_idx = wdata[3:0];
                        wr_val = regs[wdata[3:0]] + rbl_pkg::WORD_ONE;
                        done   = 1'b1;
                    end
                end
            end
            rbl_pkg::RBL_WAIT_BUF: begin
                if (buf_valid) begin
                    done = 1'b1;
                    if (op_reg == rbl_pkg::OP_BUF_BYTE) begin
                        wr_en = 1'b1;
                        if (alternate_mode_one_flag_reg && alternate_mode_two_flag_reg) begin
                            wr_val = {{8{buf_data[7]}}, buf_data};
                        end else if (alternate_mode_one_flag_reg) begin
                            wr_val = {buf_data, src_val[7:0]};
                        end else if (alternate_mode_two_flag_reg) begin
                            wr_val = {src_val[15:8], buf_data};
                        end else begin
                            wr_val = {rbl_pkg::BYTE_ZERO, buf_data};
                        end
                    end
                end
            end
            rbl_pkg::RBL_IMM_HIGH: begin
                if (op_wr) begin
                    wr_en  = 1'b1;
                    wr_idx = imm_reg_num;
                    wr_val = {wdata[7:0], imm_low_reg};
                    done   = 1'b1;
                end
            end
            rbl_pkg::RBL_IMM_BYTE: begin
                if (op_wr) begin
                    wr_en  = 1'b1;
                    wr_idx = imm_reg_num;
                    wr_val = {{8{wdata[7]}}, wdata[7:0]};
                    done   = 1'b1;
                end
            end
            default: done = 1'b0;
        endcase
    end

    // ==========
    // Sequencer
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg   <= rbl_pkg::RBL_IDLE;
            op_reg      <= 8'h00;
            imm_reg_num <= 4'h0;
            imm_low_reg <= 8'h00;
        end else begin
            case (state_reg)
                rbl_pkg::RBL_IDLE: begin
                    if (wr_op) begin
                        op_reg      <= wdata[7:0];
                        imm_reg_num <= wdata[3:0];
                        if (wdata[7:0] == rbl_pkg::OP_BUF_BYTE
                            || wdata[7:0] == rbl_pkg::OP_BUF_COLOR) begin
                            state_reg <= rbl_pkg::RBL_WAIT_BUF;
                        end else if (wdata[7:4] == rbl_pkg::OP_HI_WORD_IMM) begin
                            state_reg <= rbl_pkg::RBL_IMM_LOW;
                        end else if (wdata[7:4] == rbl_pkg::OP_HI_BYTE_IMM) begin
                            state_reg <= rbl_pkg::RBL_IMM_BYTE;
                        end
                    end
                end
                rbl_pkg::RBL_WAIT_BUF: begin
                    if (buf_valid) begin
                        state_reg <= rbl_pkg::RBL_IDLE;
                    end
                end
                rbl_pkg::RBL_IMM_LOW: begin
                    if (op_wr) begin
                        imm_low_reg <= wdata[7:0];
                        state_reg   <= rbl_pkg::RBL_IMM_HIGH;
                    end
                end
                rbl_pkg::RBL_IMM_HIGH, rbl_pkg::RBL_IMM_BYTE: begin
                    if (op_wr) begin
                        state_reg <= rbl_pkg::RBL_IDLE;
                    end
                end
                default: begin
                    state_reg <= rbl_pkg::RBL_IDLE;
                end
            endcase
        end
    end

    // ==========
    // Prefix and alternate-mode flags
    always_ff @(posedge clock) begin
        if (rst) begin
            alternate_mode_one_flag_reg   <= 1'b0;
            alternate_mode_two_flag_reg   <= 1'b0;
            prefix_reg <= 1'b0;
            src_reg    <= rbl_pkg::REG_DEFAULT;
            dst_reg    <= rbl_pkg::REG_DEFAULT;
        end else if (done) begin
            alternate_mode_one_flag_reg   <= 1'b0;
            alternate_mode_two_flag_reg   <= 1'b0;
            prefix_reg <= 1'b0;
            src_reg    <= rbl_pkg::REG_DEFAULT;
            dst_reg    <= rbl_pkg::REG_DEFAULT;
        end else if (wr_op) begin
            case (wdata[7:0])
                rbl_pkg::OP_ALTERNATE_MODE_ONE_FLAG_PREFIX: alternate_mode_one_flag_reg <= 1'b1;
                rbl_pkg::OP_ALTERNATE_MODE_TWO_FLAG_PREFIX: alternate_mode_two_flag_reg <= 1'b1;
                rbl_pkg::OP_ALT3_PREFIX: begin
                    alternate_mode_one_flag_reg <= 1'b1;
                    alternate_mode_two_flag_reg <= 1'b1;
                end
                default: begin
                    if (wdata[7:4] == rbl_pkg::OP_HI_TO) begin
                        dst_reg    <= wdata[3:0];
                        prefix_reg <= 1'b1;
                    end else if (wdata[7:4] == rbl_pkg::OP_HI_FROM) begin
                        src_reg    <= wdata[3:0];
                        prefix_reg <= 1'b1;
                    end else if (wdata[7:4] == rbl_pkg::OP_HI_WITH) begin
                        src_reg    <= wdata[3:0];
                        dst_reg    <= wdata[3:0];
                        prefix_reg <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ==========
    // Condition flags; overflow and carry are left alone here
    always_ff @(posedge clock) begin
        if (rst) begin
            sign_reg     <= 1'b0;
            zero_reg     <= 1'b0;
            overflow_reg <= 1'b0;
            carry_reg    <= 1'b0;
        end else if (wr_op) begin
            if (wdata[7:0] == rbl_pkg::OP_UPPER_MOVE) begin
                sign_reg <= src_val[15];
                zero_reg <= (src_val[15:8] == rbl_pkg::BYTE_ZERO);
            end else if (wdata[7:4] == rbl_pkg::OP_HI_INC
                         && wdata[3:0] <= rbl_pkg::REG_LAST_INC) begin
                sign_reg <= wr_val[15];
                zero_reg <= (wr_val == rbl_pkg::WORD_RESET);
            end
        end
    end

    // ==========
    // Color register and bank
    always_ff @(posedge clock) begin
        if (rst) begin
            color_reg <= 8'h00;
        end else if (state_reg == rbl_pkg::RBL_WAIT_BUF && buf_valid
                     && op_reg == rbl_pkg::OP_BUF_COLOR) begin
            color_reg <= buf_data;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            bank_reg <= rbl_pkg::BANK_RESET;
        end else if (wr && addr == rbl_pkg::ADDR_BANK) begin
            bank_reg <= wdata[7:0];
        end
    end

    // ==========
    // Register file
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < 16; i++) begin
                regs[i] <= rbl_pkg::WORD_RESET;
            end
        end else if (wr_en) begin
            regs[wr_idx] <= wr_val;
        end else if (reg_wr) begin
            regs[sel_reg] <= wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sel_reg <= 4'h0;
        end else if (wr && addr == rbl_pkg::ADDR_REG_SEL) begin
            sel_reg <= wdata[3:0];
        end
    end

    // ==========
    // Read port and busy output
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            case (addr)
                rbl_pkg::ADDR_REG_SEL:  rdata <= {12'h000, sel_reg};
                rbl_pkg::ADDR_REG_DATA: rdata <= regs[sel_reg];
                rbl_pkg::ADDR_STATUS: begin
                    rdata <= 16'h0000;
                    rdata[rbl_pkg::ST_BUSY]      <= state_reg != rbl_pkg::RBL_IDLE;
                    rdata[rbl_pkg::ST_ALTERNATE_MODE_ONE_FLAG]      <= alternate_mode_one_flag_reg;
                    rdata[rbl_pkg::ST_ALTERNATE_MODE_TWO_FLAG]      <= alternate_mode_two_flag_reg;
                    rdata[rbl_pkg::ST_PREFIX]    <= prefix_reg;
                    rdata[rbl_pkg::ST_SIGN]      <= sign_reg;
                    rdata[rbl_pkg::ST_ZERO]      <= zero_reg;
                    rdata[rbl_pkg::ST_OVERFLOW]  <= overflow_reg;
                    rdata[rbl_pkg::ST_CARRY]     <= carry_reg;
                    rdata[rbl_pkg::ST_BUF_VALID] <= buf_valid;
                end
                rbl_pkg::ADDR_COLOR:    rdata <= {8'h00, color_reg};
                rbl_pkg::ADDR_BANK:     rdata <= {8'h00, bank_reg};
                default:                rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_reg != rbl_pkg::RBL_IDLE && !done)
                    || (wr_op && (wdata[7:0] == rbl_pkg::OP_BUF_BYTE
                            || wdata[7:0] == rbl_pkg::OP_BUF_COLOR
                            || wdata[7:4] == rbl_pkg::OP_HI_WORD_IMM
                            || wdata[7:4] == rbl_pkg::OP_HI_BYTE_IMM));
        end
    end
endmodule // rbl_core
`default_nettype wire

// File: testbench/rbl_core_assertions.sv
// Port checks of the byte-load core
`timescale 1ns/10ps
`default_nettype none
module rbl_core_assertions (
    input wire logic        clock,     // Core clock
    input wire logic        rst,       // Synchronous reset
    input wire logic [3:0]  addr,      // Bus address
    input wire logic [15:0] wdata,     // Bus write data
    input wire logic        wr,        // Write strobe
    input wire logic        rd,        // Read strobe
    input wire logic        rom_ready, // ROM data valid
    input wire logic [7:0]  rom_data,  // ROM data
    input wire logic [15:0] rdata,     // Read data
    input wire logic [23:0] rom_addr,  // ROM address
    input wire logic        rom_req,   // ROM request
    input wire logic        busy       // Instruction in progress
);
    // ==========
    // Properties
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_bank_no_fetch: assert property (
        wr && addr == rbl_pkg::ADDR_BANK && !$past(wr) && !rom_req |=> !rom_req)
        else $error("bank fetch");
    a_fetch_starts: assert property (
        wr && addr == rbl_pkg::ADDR_FETCH && !busy && !rom_req |=> rom_req)
        else $error("no fetch");
    a_addr_held: assert property (
        rom_req && $past(rom_req) |-> $stable(rom_addr))
        else $error("address moved");
    a_req_waits: assert property (
        rom_req && !rom_ready |=> rom_req)
        else $error("request dropped");
    a_req_released: assert property (
        $rose(rom_ready) |-> ##[1:4] !rom_req)
        else $error("request held");
    a_busy_bounded: assert property (
        $rose(busy) |-> ##[1:60] !busy)
        else $error("busy stuck");
    a_inc_at_once: assert property (
        wr && addr == rbl_pkg::ADDR_OPCODE && !busy && wdata[7:4] == rbl_pkg::OP_HI_INC
        && wdata[3:0] != 4'hf |=> !busy)
        else $error("increment slow");
    a_move_at_once: assert property (
        wr && addr == rbl_pkg::ADDR_OPCODE && !busy && wdata[7:0] == rbl_pkg::OP_UPPER_MOVE
        |=> !busy)
        else $error("move slow");
    a_word_steps: assert property (
        wr && addr == rbl_pkg::ADDR_OPCODE && !busy && wdata[7:4] == rbl_pkg::OP_HI_WORD_IMM
        |=> busy)
        else $error("word immediate early");
    a_rdata_idle: assert property (
        !$past(rd) |-> rdata == 16'h0000)
        else $error("stray read data");
    a_reset_quiet: assert property (
        $fell(rst) |-> !rom_req && !busy && rdata == 16'h0000)
        else $error("reset not quiet");

    c_fetch_done: cover property ($fell(rom_req));
    c_load_done: cover property ($fell(busy));
    c_word_imm: cover property (wr && wdata[7:4] == rbl_pkg::OP_HI_WORD_IMM);
endmodule // rbl_core_assertions
`default_nettype wire

// File: testbench/rbl_rom_model.sv
// Program ROM model with a set answer delay
`timescale 1ns/10ps
`default_nettype none
module rbl_rom_model (
    input  wire logic        clock,     // Core clock
    input  wire logic        rst,       // Synchronous reset
    input  wire logic        rom_req,   // Read request
    input  wire logic [23:0] rom_addr,  // Bank and pointer
    input  wire logic [3:0]  lat,       // Answer delay in cycles
    output logic             rom_ready, // Data valid
    output logic      [7:0]  rom_data   // Data byte
);
    logic [3:0] wait_cnt;

    initial begin
        rom_ready = 1'b0;
        rom_data  = 8'h3c;
        wait_cnt  = 4'h0;
    end

    // Data lines toggle whenever no valid byte is offered
    always @(posedge clock) begin
        if (rst || !rom_req) begin
            wait_cnt  <= 4'h0;
            rom_ready <= 1'b0;
            rom_data  <= ~rom_data;
        end else if (!rom_ready && wait_cnt >= lat) begin
            rom_ready <= 1'b1;
            rom_data  <= rom_addr[7:0] ^ rom_addr[15:8] ^ rom_addr[23:16] ^ 8'h5a;
        end else if (!rom_ready) begin
            wait_cnt <= wait_cnt + 4'h1;
            rom_data <= ~rom_data;
        end
    end
endmodule // rbl_rom_model
`default_nettype wire

// File: testbench/testbench.sv
// Bench for the byte-load core
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        clock;
    logic        rst;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic        rom_ready;
    logic [7:0]  rom_data;
    logic [15:0] rdata;
    logic [23:0] rom_addr;
    logic        rom_req;
    logic        busy;
    logic [3:0]  rom_lat;
    logic [15:0] got;
    logic [15:0] ptr;
    logic [15:0] val;
    logic [15:0] exp_val;
    logic [7:0]  bank_val;
    logic [7:0]  bt;
    logic [3:0]  src;
    logic [3:0]  dst;
    logic [3:0]  n;
    integer      err_total = 0;
    integer      checked = 0;
    integer      cycles = 0;
    integer      seed = 61183;
    integer      k;
    integer      i;

    rbl_core uut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rom_ready(rom_ready), .rom_data(rom_data), .rdata(rdata), .rom_addr(rom_addr),
        .rom_req(rom_req), .busy(busy));
    rbl_rom_model rom (.clock(clock), .rst(rst), .rom_req(rom_req), .rom_addr(rom_addr),
        .lat(rom_lat), .rom_ready(rom_ready), .rom_data(rom_data));

    // ==========
    // Helpers
    function automatic logic [7:0] rom_fn(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
    endfunction

    task automatic print_verdict;
        if (err_total == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] g, input logic [15:0] e);
        checked = checked + 1;
        if (g !== e) begin
            err_total = err_total + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask

    task automatic bus_rd(input logic [3:0] a);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1;
        got = rdata;
    endtask

    task automatic op(input logic [7:0] c);
        bus_wr(rbl_pkg::ADDR_OPCODE, {8'h00, c});
    endtask

    task automatic set_reg(input logic [3:0] r, input logic [15:0] d);
        bus_wr(rbl_pkg::ADDR_REG_SEL, {12'h000, r});
        bus_wr(rbl_pkg::ADDR_REG_DATA, d);
    endtask

    task automatic get_reg(input logic [3:0] r);
        bus_wr(rbl_pkg::ADDR_REG_SEL, {12'h000, r});
        bus_rd(rbl_pkg::ADDR_REG_DATA);
    endtask

    task automatic wait_idle;
        integer j;
        #1;
        for (j = 0; j < 60 && busy !== 1'b0; j++) begin
            @(posedge clock);
            #1;
        end
        if (j == 60) check({15'h0000, busy}, 16'h0000);
    endtask

    // ==========
    // Clock, timeout and sequence
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            print_verdict;
        end
    end

    initial begin
        rst = 1'b1;
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        rom_lat = 4'h2;
        ptr = 16'h0000;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        bus_rd(rbl_pkg::ADDR_STATUS);
        check(got, 16'h0000);
        for (k = 0; k < 12; k++) begin
            src = (k < 6) ? 4'(($random(seed) & 3) + 1) : 4'h0;
            dst = (k < 6 && k != 0) ? 4'(($random(seed) & 3) + 8) : 4'h0;
            val = 16'($random(seed));
            set_reg(src, val);
            if (src != 4'h0) op({rbl_pkg::OP_HI_FROM, src});
            if (dst != 4'h0) op({rbl_pkg::OP_HI_TO, dst});
            bank_val = 8'($random(seed));
            bus_wr(rbl_pkg::ADDR_BANK, {8'h00, bank_val});
            repeat (3) @(posedge clock);
            #1;
            check({15'h0000, rom_req}, 16'h0000);
            rom_lat <= 4'($random(seed) & 7);
            if (k % 2 == 0) begin
                ptr = 16'($random(seed));
                set_reg(rbl_pkg::REG_ROM_POINTER, ptr);
            end else begin
                bus_wr(rbl_pkg::ADDR_FETCH, 16'h0000);
            end
            #1;
            for (i = 0; i < 8 && rom_req !== 1'b1; i++) begin
                @(posedge clock);
                #1;
            end
            check(rom_addr[15:0], ptr);
            check({8'h00, rom_addr[23:16]}, {8'h00, bank_val});
            if (k < 6) begin
                got = 16'h0000;
                for (i = 0; i < 30 && got[rbl_pkg::ST_BUF_VALID] !== 1'b1; i++) begin
                    bus_rd(rbl_pkg::ADDR_STATUS);
                end
            end
            case (k % 6)
                2: op(rbl_pkg::OP_ALTERNATE_MODE_ONE_FLAG_PREFIX);
                3: op(rbl_pkg::OP_ALTERNATE_MODE_TWO_FLAG_PREFIX);
                4: op(rbl_pkg::OP_ALT3_PREFIX);
                default: ;
            endcase
            op((k % 6 == 5) ? rbl_pkg::OP_BUF_COLOR : rbl_pkg::OP_BUF_BYTE);
            wait_idle;
            bt = rom_fn({bank_val, ptr});
            case (k % 6)
                2: exp_val = {bt, val[7:0]};
                3: exp_val = {val[15:8], bt};
                4: exp_val = {{8{bt[7]}}, bt};
                default: exp_val = {8'h00, bt};
            endcase
            if (k % 6 == 5) begin
                bus_rd(rbl_pkg::ADDR_COLOR);
                check(got, {8'h00, bt});
            end else begin
                get_reg(dst);
                check(got, exp_val);
            end
            bus_rd(rbl_pkg::ADDR_STATUS);
            check(got & 16'h00ce, 16'h0000);
        end
        for (k = 0; k < 8; k++) begin
            n = 4'($unsigned($random(seed)) % 13);
            val = (k == 0) ? 16'hffff : (k == 1) ? 16'h0042 : 16'($random(seed));
            set_reg(n, val);
            op({rbl_pkg::OP_HI_FROM, n});
            op({rbl_pkg::OP_HI_TO, 4'hd});
            op(rbl_pkg::OP_UPPER_MOVE);
            get_reg(4'hd);
            check(got, {8'h00, val[15:8]});
            bus_rd(rbl_pkg::ADDR_STATUS);
            check({14'h0000, got[rbl_pkg::ST_ZERO], got[rbl_pkg::ST_SIGN]},
                {14'h0000, val[15:8] == 8'h00, val[15]});
            check(got & 16'h00ce, 16'h0000);
            set_reg(n, val);
            op({rbl_pkg::OP_HI_INC, n});
            get_reg(n);
            check(got, val + 16'h0001);
            bt = (k == 2) ? 8'h80 : (k == 3) ? 8'h7f : 8'($random(seed));
            op({rbl_pkg::OP_HI_BYTE_IMM, n});
            op(bt);
            wait_idle;
            get_reg(n);
            check(got, {{8{bt[7]}}, bt});
            val = 16'($random(seed));
            n = (k == 4) ? 4'hf : n;
            op({rbl_pkg::OP_HI_WORD_IMM, n});
            op(val[7:0]);
            op(val[15:8]);
            wait_idle;
            get_reg(n);
            check(got, val);
        end
        print_verdict;
    end
endmodule // testbench

bind rbl_core rbl_core_assertions chk (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rom_ready(rom_ready), .rom_data(rom_data), .rdata(rdata),
    .rom_addr(rom_addr), .rom_req(rom_req), .busy(busy));
`default_nettype wire
